// [verilog/ddrbu_ctrl.sv]
// DDR3 controller bring-up: reset hold, init sequence, calibration, mapping, ECC
`timescale 1ns/1ps
`default_nettype none
`include "ddrbu_regs.svh"
module ddrbu_ctrl #(
    parameter int unsigned RST_CYC = (`DDRBU_T_RSTLO_NS * 1000 + `DDRBU_CLK_PS - 1) / `DDRBU_CLK_PS,
    parameter int unsigned CKE_CYC = (`DDRBU_T_CKE_NS * 1000 + `DDRBU_CLK_PS - 1) / `DDRBU_CLK_PS,
    parameter int unsigned CAL_CYC = (`DDRBU_T_CAL_NS * 1000 + `DDRBU_CLK_PS - 1) / `DDRBU_CLK_PS
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        ce,
    input  wire logic        memResetHold,
    input  wire logic        initStart,
    input  wire logic        ddrMode,
    input  wire logic        ddrWidth,
    input  wire logic        dualRow,
    input  wire logic        bankCnt,
    input  wire logic [3:0]  msbRowAddr,
    input  wire logic [3:0]  msbColAddr,
    input  wire logic        eccEna,
    input  wire logic [15:0] initDly,
    input  wire logic [7:0]  mdsetDly,
    input  wire logic [15:0] mr0Val,
    input  wire logic [15:0] mr1Val,
    input  wire logic [15:0] mr2Val,
    input  wire logic [15:0] mr3Val,
    input  wire logic        calWrite,
    input  wire logic [7:0]  calCode,
    input  wire logic [29:0] hostAddr,
    input  wire logic [7:0]  wrData,
    input  wire logic [7:0]  rdData,
    input  wire logic [7:0]  rdCheck,
    output logic             calInProgress,
    output logic             initDone,
    output logic             ddrCk,
    output logic             memResetN,
    output logic             cke,
    output logic [1:0]       csN,
    output logic             rasN,
    output logic             casN,
    output logic             weN,
    output logic [2:0]       ba,
    output logic [15:0]      memAddr,
    output logic             mapCs,
    output logic [2:0]       mapBank,
    output logic [15:0]      mapRow,
    output logic [15:0]      mapCol,
    output logic             mapFault,
    output logic [5:0]       capLog2,
    output logic [7:0]       eccCheck,
    output logic             eccErr
);
    ddrbu_pkg::ddrbu_ctl_t r;
    ddrbu_pkg::ddrbu_ctl_t n;

    logic        tLoad;
    logic [16:0] tVal;
    logic        tBusy;
    logic        calLoad;
    logic        calOk;
    logic [15:0] mrSel;
    logic [1:0]  ranksN;
    logic        laneShift;
    logic [5:0]  colBits;
    logic [5:0]  rowBits;
    logic [5:0]  bankBits;
    logic [5:0]  physLog2;
    logic [5:0]  availLog2;
    logic [29:0] aCol;
    logic [29:0] aBank;
    logic [29:0] aRow;

    // ------------------------------------------------------------
    // Check byte
    // ------------------------------------------------------------
    // Detect-only code: each check bit folds three data bits
    function automatic logic [7:0] eccEnc(input logic [7:0] d);
        logic [7:0] c;
        c = '0;
        for (int i = 0; i < 8; i++) begin
            c[i] = d[i] ^ d[(i + 1) % 8] ^ d[(i + 3) % 8];
        end
        return c;
    endfunction

    // ------------------------------------------------------------
    // Waits and calibration
    // ------------------------------------------------------------
    ddrbu_timer #(.W(17)) u_waitTmr (
        .clk     (clk),
        .rst_b   (rst_b),
        .ce      (ce),
        .load    (tLoad),
        .loadVal (tVal),
        .busy    (tBusy)
    );

    // Only the agreed code starts it; other writes are ignored
    assign calOk   = calWrite && calCode == `DDRBU_CAL_CODE;
    assign calLoad = calOk && !calInProgress;

    ddrbu_timer #(.W(8)) u_calTmr (
        .clk     (clk),
        .rst_b   (rst_b),
        .ce      (ce),
        .load    (calLoad),
        .loadVal (8'(CAL_CYC)),
        .busy    (calInProgress)
    );

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        case (r.mrIdx)
            2'h0:    mrSel = mr0Val;
            2'h1:    mrSel = mr1Val;
            2'h2:    mrSel = mr2Val;
            default: mrSel = mr3Val;
        endcase
    end

    // Init commands go to every populated rank at once
    assign ranksN = dualRow ? 2'b00 : 2'b10;

    always_comb begin
        n       = r;
        tLoad   = 1'b0;
        tVal    = '0;
        n.cmd   = `DDRBU_CMD_NOP;
        n.csN   = 2'b11;
        n.ddrCk = ~r.ddrCk;
        case (r.st)
            ddrbu_pkg::ST_HOLD: begin
                if (!memResetHold) n.st = ddrbu_pkg::ST_IDLE;
            end
            ddrbu_pkg::ST_IDLE: begin
                // Timings are sampled from here on, so they must be set first
                if (initStart && ddrMode == `DDRBU_MODE_DDR3 && !calInProgress) begin
                    n.st  = ddrbu_pkg::ST_RSTLO;
                    tLoad = 1'b1;
                    tVal  = 17'(RST_CYC);
                end
            end
            ddrbu_pkg::ST_RSTLO: begin
                if (!tBusy) begin
                    n.memResetN = 1'b1;
                    n.st        = ddrbu_pkg::ST_CKEWT;
                    tLoad       = 1'b1;
                    tVal        = 17'(CKE_CYC);
                end
            end
            ddrbu_pkg::ST_CKEWT: begin
                if (!tBusy) begin
                    n.cke = 1'b1;
                    n.st  = ddrbu_pkg::ST_XPR;
                    tLoad = 1'b1;
                    tVal  = {1'b0, initDly} + 17'h00001;
                end
            end
            ddrbu_pkg::ST_XPR: begin
                if (!tBusy) begin
                    n.st    = ddrbu_pkg::ST_MRS;
                    n.mrIdx = `DDRBU_MR_FIRST;
                end
            end
            ddrbu_pkg::ST_MRS: begin
                n.cmd  = `DDRBU_CMD_MRS;
                n.csN  = ranksN;
                n.ba   = {1'b0, r.mrIdx};
                n.addr = mrSel;
                n.st   = ddrbu_pkg::ST_MRSWT;
                tLoad  = 1'b1;
                tVal   = {9'h000, mdsetDly} + 17'h00001;
            end
            ddrbu_pkg::ST_MRSWT: begin
                if (!tBusy) begin
                    // Order 2, 3, 1, 0 as power-up requires
                    case (r.mrIdx)
                        2'h2:    n.mrIdx = 2'h3;
                        2'h3:    n.mrIdx = 2'h1;
                        default: n.mrIdx = 2'h0;
                    endcase
                    n.st = (r.mrIdx == 2'h0) ? ddrbu_pkg::ST_ZQ : ddrbu_pkg::ST_MRS;
                end
            end
            ddrbu_pkg::ST_ZQ: begin
                n.cmd  = `DDRBU_CMD_ZQCL;
                n.csN  = ranksN;
                n.addr = '0;
                n.addr[`DDRBU_ZQ_LONG_BIT] = 1'b1;
                n.st   = ddrbu_pkg::ST_ZQWT;
                tLoad  = 1'b1;
                tVal   = `DDRBU_T_ZQINIT_CYC;
            end
            ddrbu_pkg::ST_ZQWT: begin
                if (!tBusy) begin
                    n.initDone = 1'b1;
                    n.st       = ddrbu_pkg::ST_DONE;
                end
            end
            ddrbu_pkg::ST_DONE: begin
                n.st = ddrbu_pkg::ST_DONE;
            end
            default: begin
                n.st = ddrbu_pkg::ST_HOLD;
            end
        endcase
        // Hold wins over every sequencer step and aborts its wait; a calibration in progress runs on
        if (memResetHold) begin
            n.st        = ddrbu_pkg::ST_HOLD;
            n.memResetN = 1'b0;
            n.cke       = 1'b0;
            n.initDone  = 1'b0;
            n.cmd       = `DDRBU_CMD_NOP;
            n.csN       = 2'b11;
            tLoad       = 1'b1;
            tVal        = '0;
        end

        // ------------------------------------------------------------
        // Address map and capacity
        // ------------------------------------------------------------
        // With ECC the second lane carries check bytes, not data
        laneShift = ddrWidth && !eccEna;
        colBits   = {2'b00, msbColAddr} + 6'h01;
        rowBits   = {2'b00, msbRowAddr} + 6'h01;
        bankBits  = bankCnt ? `DDRBU_BANK8_BITS : `DDRBU_BANK4_BITS;
        physLog2  = colBits + rowBits + bankBits + {5'h00, ddrWidth} + {5'h00, dualRow};
        if (physLog2 > `DDRBU_MAX_LOG2) physLog2 = `DDRBU_MAX_LOG2;
        availLog2 = physLog2 - {5'h00, eccEna};
        aCol      = hostAddr >> laneShift;
        aBank     = aCol >> colBits;
        aRow      = aBank >> bankBits;
        n.mapCol  = 16'(aCol & ((30'h1 << colBits) - 30'h1));
        n.mapBank = 3'(aBank & ((30'h1 << bankBits) - 30'h1));
        n.mapRow  = 16'(aRow & ((30'h1 << rowBits) - 30'h1));
        // Rank is the bit above one rank's span, so memory is contiguous
        n.mapCs    = dualRow && ((aRow >> rowBits) != 30'h0);
        n.mapFault = (hostAddr >> availLog2) != 30'h0;
        n.capLog2  = availLog2;
        // Check only meaningful when both lanes are fitted
        n.eccCheck = eccEna ? eccEnc(wrData) : 8'h00;
        n.eccErr   = eccEna && ddrWidth && (eccEnc(rdData) != rdCheck);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            r     <= '0;
            r.st  <= ddrbu_pkg::ST_HOLD;
            r.csN <= 2'b11;
            r.cmd <= `DDRBU_CMD_NOP;
        end else if (ce) begin
            r <= n;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign initDone  = r.initDone;
    assign ddrCk     = r.ddrCk;
    assign memResetN = r.memResetN;
    assign cke       = r.cke;
    assign csN       = r.csN;
    assign {rasN, casN, weN} = r.cmd;
    assign ba        = r.ba;
    assign memAddr   = r.addr;
    assign mapCs     = r.mapCs;
    assign mapBank   = r.mapBank;
    assign mapRow    = r.mapRow;
    assign mapCol    = r.mapCol;
    assign mapFault  = r.mapFault;
    assign capLog2   = r.capLog2;
    assign eccCheck  = r.eccCheck;
    assign eccErr    = r.eccErr;

    a_hold_quiet: assert property (@(posedge clk) disable iff (!rst_b)
        (ce && memResetHold) |=> (csN == 2'b11 && !memResetN && !cke && !initDone))
        else $error("commands issued while reset hold set");
    a_mode_gate: assert property (@(posedge clk) disable iff (!rst_b)
        (ce && r.st == ddrbu_pkg::ST_IDLE && ddrMode != `DDRBU_MODE_DDR3) |=> r.st != ddrbu_pkg::ST_RSTLO)
        else $error("init started without DDR3 mode");
    a_mrs_value: assert property (@(posedge clk) disable iff (!rst_b)
        (ce && !memResetHold && r.st == ddrbu_pkg::ST_MRS) |=>
            ({rasN, casN, weN} == `DDRBU_CMD_MRS && memAddr == $past(mrSel) && ba[1:0] == $past(r.mrIdx)))
        else $error("mode register write carries wrong value");
    a_cal_start: assert property (@(posedge clk) disable iff (!rst_b)
        (ce && calOk && !calInProgress && !memResetHold) |=> calInProgress)
        else $error("calibration did not start on code");
    a_cal_ignore: assert property (@(posedge clk) disable iff (!rst_b)
        (ce && calWrite && calCode != `DDRBU_CAL_CODE && !calInProgress) |=> !calInProgress)
        else $error("calibration started on wrong code");
    a_cap_limit: assert property (@(posedge clk) disable iff (!rst_b)
        capLog2 <= `DDRBU_MAX_LOG2)
        else $error("capacity above one gigabyte");
    a_ecc_code: assert property (@(posedge clk) disable iff (!rst_b)
        (ce && eccEna) |=> eccCheck == eccEnc($past(wrData)))
        else $error("check byte does not match write data");
    a_ecc_half: assert property (@(posedge clk) disable iff (!rst_b)
        (ce && eccEna && hostAddr[29]) |=> mapFault)
        else $error("upper half visible with ECC");
    a_single_rank: assert property (@(posedge clk) disable iff (!rst_b)
        (ce && !dualRow) |=> (!mapCs && csN[1]))
        else $error("second rank used in single-row mode");
    a_ck_toggle: assert property (@(posedge clk) disable iff (!rst_b)
        ce |=> ddrCk != $past(ddrCk))
        else $error("memory clock stalled");
endmodule // ddrbu_ctrl
`default_nettype wire

// [verilog/ddrbu_regs.svh]
// Constants for the DDR3 controller bring-up block
// How it works
// - Controller runs at 200 MHz, 5 ns
// - One or two lanes, one or two ranks
// - Up to sixteen row/column address bits
// - Addressable memory capped at one gigabyte
// - ECC uses a lane, encodes and checks
// - With ECC, software sees half memory
// - Init trigger runs power-up, writes modes
// - Code 0xef starts calibration, busy clears
// - Rank chosen from address width, banks
`ifndef DDRBU_REGS_SVH
`define DDRBU_REGS_SVH

`define DDRBU_CLK_PS        5000
`define DDRBU_T_RSTLO_NS    200000
`define DDRBU_T_CKE_NS      500000
`define DDRBU_T_CAL_NS      320
`define DDRBU_T_ZQINIT_CYC  17'h00200
`define DDRBU_CAL_CODE      8'hef
`define DDRBU_MODE_DDR3     1'b1
`define DDRBU_MAX_LOG2      6'h1e
`define DDRBU_BANK8_BITS    6'h03
`define DDRBU_BANK4_BITS    6'h02
`define DDRBU_CMD_NOP       3'h7
`define DDRBU_CMD_MRS       3'h0
`define DDRBU_CMD_ZQCL      3'h6
`define DDRBU_ZQ_LONG_BIT   10
`define DDRBU_MR_FIRST      2'h2

`endif

// [verilog/ddrbu_pkg.sv]
// Types shared by the DDR3 bring-up block
package ddrbu_pkg;

    typedef enum logic [9:0] {
        ST_HOLD  = 10'h001,
        ST_IDLE  = 10'h002,
        ST_RSTLO = 10'h004,
        ST_CKEWT = 10'h008,
        ST_XPR   = 10'h010,
        ST_MRS   = 10'h020,
        ST_MRSWT = 10'h040,
        ST_ZQ    = 10'h080,
        ST_ZQWT  = 10'h100,
        ST_DONE  = 10'h200
    } ddrbu_state_t;

    typedef struct packed {
        ddrbu_state_t st;
        logic [1:0]   mrIdx;
        logic         ddrCk;
        logic         memResetN;
        logic         cke;
        logic         initDone;
        logic [1:0]   csN;
        logic [2:0]   cmd;
        logic [2:0]   ba;
        logic [15:0]  addr;
        logic         mapCs;
        logic [2:0]   mapBank;
        logic [15:0]  mapRow;
        logic [15:0]  mapCol;
        logic         mapFault;
        logic [5:0]   capLog2;
        logic [7:0]   eccCheck;
        logic         eccErr;
    } ddrbu_ctl_t;

endpackage

// [verilog/ddrbu_timer.sv]
// Down-counter for bring-up waits
`timescale 1ns/1ps
`default_nettype none
module ddrbu_timer #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic         ce,
    input  wire logic         load,
    input  wire logic [W-1:0] loadVal,
    output logic              busy
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic         busy;
    } ddrbu_tmr_t;

    ddrbu_tmr_t r;
    ddrbu_tmr_t n;

    // Busy lasts exactly loadVal cycles; a load of zero cancels
    always_comb begin
        n = r;
        if (load) begin
            n.cnt  = loadVal;
            n.busy = (loadVal != '0);
        end else if (r.busy) begin
            n.cnt  = r.cnt - W'(1);
            n.busy = (r.cnt != W'(1));
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            r <= '0;
        end else if (ce) begin
            r <= n;
        end
    end

    assign busy = r.busy;

    a_timer_expiry: assert property (@(posedge clk) disable iff (!rst_b)
        (ce && r.busy && r.cnt == W'(1) && !load) |=> !busy)
        else $error("timer did not expire on count one");
    // A reload right after the start (reset hold) may legally cut the wait short
    a_timer_start: assert property (@(posedge clk) disable iff (!rst_b)
        (ce && load && loadVal > W'(1)) |=> busy ##1 (busy || !$past(ce) || $past(load)))
        else $error("timer dropped busy too early");
endmodule // ddrbu_timer
`default_nettype wire

// [sim/ddrbu_mem_model.sv]
// Behavioural pair of DDR3 modules watching the bring-up command bus
`timescale 1ns/1ps
`default_nettype none
module ddrbu_mem_model (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        memResetN,
    input  wire logic        cke,
    input  wire logic [1:0]  csN,
    input  wire logic        rasN,
    input  wire logic        casN,
    input  wire logic        weN,
    input  wire logic [2:0]  ba,
    input  wire logic [15:0] memAddr,
    input  wire logic        store,
    input  wire logic [7:0]  wrByte,
    input  wire logic [7:0]  wrChk,
    input  wire logic        corrupt,
    output logic      [7:0]  rdData,
    output logic      [7:0]  rdCheck,
    output logic      [63:0] modeRegs,
    output logic      [7:0]  mrOrder,
    output logic      [3:0]  mrsCount,
    output logic      [15:0] mrsGap,
    output logic      [1:0]  mrsCs,
    output logic      [3:0]  zqCount,
    output logic             cmdViolation
);
    logic [15:0] sinceMrs;
    logic [7:0]  dataLane;
    logic [7:0]  checkLane;
    wire         cmdValid = (csN != 2'h3);
    wire         isMrs    = cmdValid && !rasN && !casN && !weN;
    wire         isZq     = cmdValid && rasN && casN && !weN;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sinceMrs <= 16'h0000;
            modeRegs <= 64'h0;
            mrOrder <= 8'h00;
            mrsCount <= 4'h0;
            mrsGap <= 16'h0000;
            mrsCs <= 2'h3;
            zqCount <= 4'h0;
            cmdViolation <= 1'b0;
            dataLane <= 8'h00;
            checkLane <= 8'h00;
        end else begin
            sinceMrs <= sinceMrs + 16'h0001;
            if (cmdValid && (!memResetN || !cke)) begin
                cmdViolation <= 1'b1;
            end
            if (isMrs) begin
                modeRegs[ba[1:0]*16 +: 16] <= memAddr;
                mrOrder <= {mrOrder[5:0], ba[1:0]};
                mrsCount <= mrsCount + 4'h1;
                mrsGap <= sinceMrs;
                mrsCs <= csN;
                sinceMrs <= 16'h0001;
            end
            if (isZq && memAddr[10]) begin
                zqCount <= zqCount + 4'h1;
            end
            if (store) begin
                dataLane <= wrByte;
                checkLane <= wrChk;
            end
        end
    end

    // One flipped data bit on request, so a read check has something to catch
    assign rdData = corrupt ? (dataLane ^ 8'h01) : dataLane;
    assign rdCheck = checkLane;
endmodule  // ddrbu_mem_model
`default_nettype wire

// [sim/ddrbu_ctrl_tb.sv]
// Self-checking bench for the DDR3 bring-up controller
`timescale 1ns/1ps
`default_nettype none
module ddrbu_ctrl_tb;
    localparam int unsigned RST_CYC = 8;
    localparam int unsigned CKE_CYC = 8;
    localparam int unsigned CAL_CYC = 4;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        ce = 1'b1;
    logic        memResetHold = 1'b1;
    logic        initStart = 1'b0;
    logic        ddrMode = 1'b1;
    logic        ddrWidth = 1'b1;
    logic        dualRow = 1'b1;
    logic        bankCnt = 1'b1;
    logic [3:0]  msbRowAddr = 4'hc;
    logic [3:0]  msbColAddr = 4'h9;
    logic        eccEna = 1'b0;
    logic [15:0] initDly = 16'h0003;
    logic [7:0]  mdsetDly = 8'h05;
    // Example part: RL 9, WL 7, tWR 12
    logic [15:0] mr0Val = 16'h0c50;
    logic [15:0] mr1Val = 16'h0040;
    logic [15:0] mr2Val = 16'h0010;
    logic [15:0] mr3Val = 16'h0000;
    logic        calWrite = 1'b0;
    logic [7:0]  calCode = 8'h00;
    logic [29:0] hostAddr = 30'h0;
    logic [7:0]  wrData = 8'h00;
    logic        store = 1'b0;
    logic        corrupt = 1'b0;
    logic [7:0]  rdData, rdCheck, eccCheck, mrOrder;
    logic        calInProgress, initDone, ddrCk, memResetN, cke, rasN, casN, weN, mapCs, mapFault, eccErr;
    logic        cmdViolation;
    logic [1:0]  csN, mrsCs;
    logic [2:0]  ba, mapBank;
    logic [15:0] memAddr, mapRow, mapCol, mrsGap;
    logic [5:0]  capLog2;
    logic [63:0] modeRegs;
    logic [3:0]  mrsCount, zqCount;
    int          failures = 0;
    int          tests_run = 0;
    int          cycles = 0;

    ddrbu_ctrl #(.RST_CYC(RST_CYC), .CKE_CYC(CKE_CYC), .CAL_CYC(CAL_CYC)) i_ddrbu_ctrl (
        .clk(clk), .rst_b(rst_b), .ce(ce), .memResetHold(memResetHold), .initStart(initStart),
        .ddrMode(ddrMode), .ddrWidth(ddrWidth), .dualRow(dualRow), .bankCnt(bankCnt),
        .msbRowAddr(msbRowAddr), .msbColAddr(msbColAddr), .eccEna(eccEna), .initDly(initDly),
        .mdsetDly(mdsetDly), .mr0Val(mr0Val), .mr1Val(mr1Val), .mr2Val(mr2Val), .mr3Val(mr3Val),
        .calWrite(calWrite), .calCode(calCode), .hostAddr(hostAddr), .wrData(wrData), .rdData(rdData),
        .rdCheck(rdCheck), .calInProgress(calInProgress), .initDone(initDone), .ddrCk(ddrCk),
        .memResetN(memResetN), .cke(cke), .csN(csN), .rasN(rasN), .casN(casN), .weN(weN), .ba(ba),
        .memAddr(memAddr), .mapCs(mapCs), .mapBank(mapBank), .mapRow(mapRow), .mapCol(mapCol),
        .mapFault(mapFault), .capLog2(capLog2), .eccCheck(eccCheck), .eccErr(eccErr));

    ddrbu_mem_model i_ddrbu_mem_model (
        .clk(clk), .rst_b(rst_b), .memResetN(memResetN), .cke(cke), .csN(csN), .rasN(rasN),
        .casN(casN), .weN(weN), .ba(ba), .memAddr(memAddr), .store(store), .wrByte(wrData),
        .wrChk(eccCheck), .corrupt(corrupt), .rdData(rdData), .rdCheck(rdCheck), .modeRegs(modeRegs),
        .mrOrder(mrOrder), .mrsCount(mrsCount), .mrsGap(mrsGap), .mrsCs(mrsCs), .zqCount(zqCount),
        .cmdViolation(cmdViolation));

    always #2.5 clk = ~clk;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // Map outputs are registered, so look one edge after the inputs move
    task automatic apply(input logic [3:0] col, input logic [3:0] row, input logic bank8, input logic w,
                         input logic d, input logic e, input logic [29:0] a);
        @(negedge clk);
        msbColAddr = col;
        msbRowAddr = row;
        bankCnt = bank8;
        ddrWidth = w;
        dualRow = d;
        eccEna = e;
        hostAddr = a;
        @(negedge clk);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_hold;
        logic ckWas;
        initStart = 1'b1;
        repeat (20) @(negedge clk);
        initStart = 1'b0;
        chk(memResetN, 1'b0);
        chk(cke, 1'b0);
        chk(csN, 2'h3);
        chk(initDone, 1'b0);
        ckWas = ddrCk;
        @(negedge clk);
        chk(ddrCk, !ckWas);
        // Enable low must freeze the memory clock too
        ce = 1'b0;
        ckWas = ddrCk;
        repeat (2) @(negedge clk);
        chk(ddrCk, ckWas);
        ce = 1'b1;
        memResetHold = 1'b0;
        repeat (2) @(negedge clk);
        $display("t_hold done");
    endtask

    task automatic t_cal;
        int n;
        calWrite = 1'b1;
        calCode = 8'hee;
        @(negedge clk);
        calWrite = 1'b0;
        @(negedge clk);
        chk(calInProgress, 1'b0);
        calWrite = 1'b1;
        calCode = 8'hef;
        @(negedge clk);
        calWrite = 1'b0;
        initStart = 1'b1;
        n = 0;
        while (calInProgress === 1'b1 && n < 100) begin
            n++;
            @(negedge clk);
            initStart = 1'b0;
        end
        chk(n, CAL_CYC);
        repeat (RST_CYC + 4) @(negedge clk);
        chk(memResetN, 1'b0);
        ddrMode = 1'b0;
        initStart = 1'b1;
        @(negedge clk);
        initStart = 1'b0;
        repeat (RST_CYC + 4) @(negedge clk);
        chk(memResetN, 1'b0);
        $display("t_cal done");
    endtask

    task automatic t_init;
        int n;
        ddrMode = 1'b1;
        initStart = 1'b1;
        n = 0;
        @(negedge clk);
        initStart = 1'b0;
        while (memResetN !== 1'b1 && n < 100) begin
            n++;
            @(negedge clk);
        end
        chk(n, RST_CYC + 1);
        n = 0;
        while (cke !== 1'b1 && n < 100) begin
            n++;
            @(negedge clk);
        end
        chk(n, CKE_CYC + 1);
        n = 0;
        while (initDone !== 1'b1 && n < 3000) begin
            n++;
            @(negedge clk);
        end
        chk(initDone, 1'b1);
        chk(mrsCount, 4'h4);
        chk(mrOrder, 8'hb4);
        chk(modeRegs, {mr3Val, mr2Val, mr1Val, mr0Val});
        // Timer wait of mdsetDly+1 plus two sequencer steps between commands
        chk(mrsGap, 16'(mdsetDly) + 16'h0003);
        chk(mrsCs, 2'h0);
        chk(zqCount, 4'h1);
        chk(cmdViolation, 1'b0);
        memResetHold = 1'b1;
        @(negedge clk);
        chk({initDone, memResetN, cke}, 3'h0);
        memResetHold = 1'b0;
        $display("t_init done");
    endtask

    task automatic t_map;
        apply(4'h9, 4'hf, 1'b1, 1'b1, 1'b1, 1'b0, 30'h3fffffff);
        chk(capLog2, 6'h1e);
        chk(mapFault, 1'b0);
        apply(4'h9, 4'hf, 1'b1, 1'b1, 1'b1, 1'b1, 30'h20000000);
        chk(capLog2, 6'h1d);
        chk(mapFault, 1'b1);
        apply(4'h9, 4'hc, 1'b1, 1'b1, 1'b1, 1'b0, 30'h08000000);
        chk({mapCs, mapFault, mapRow}, 18'h20000);
        apply(4'h9, 4'hc, 1'b0, 1'b1, 1'b1, 1'b0, 30'h04000000);
        chk({mapCs, capLog2}, 7'h5b);
        apply(4'h9, 4'hf, 1'b1, 1'b0, 1'b0, 1'b0, 30'h10000000);
        chk({mapCs, mapRow, capLog2}, 23'h20001d);
        apply(4'h9, 4'hc, 1'b1, 1'b1, 1'b1, 1'b0, 30'h00000002);
        chk(mapCol, 16'h0001);
        // Column 2, bank 5 on one lane
        apply(4'h9, 4'hc, 1'b1, 1'b0, 1'b1, 1'b0, 30'h00001402);
        chk(mapCol, 16'h0002);
        chk(mapBank, 3'h5);
        $display("t_map done");
    endtask

    task automatic t_ecc;
        apply(4'h9, 4'hc, 1'b1, 1'b1, 1'b1, 1'b1, 30'h0);
        wrData = 8'h01;
        @(negedge clk);
        chk(eccCheck, 8'ha1);
        wrData = 8'h80;
        @(negedge clk);
        chk(eccCheck, 8'hd0);
        store = 1'b1;
        @(negedge clk);
        store = 1'b0;
        repeat (2) @(negedge clk);
        chk(eccErr, 1'b0);
        corrupt = 1'b1;
        @(negedge clk);
        chk(eccErr, 1'b1);
        ddrWidth = 1'b0;
        @(negedge clk);
        chk(eccErr, 1'b0);
        eccEna = 1'b0;
        corrupt = 1'b0;
        @(negedge clk);
        chk(eccCheck, 8'h00);
        $display("t_ecc done");
    endtask

    // ------------------------------------------------------------
    // Main sequence and hang guard
    // ------------------------------------------------------------
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            wrap_up;
        end
    end

    initial begin
        repeat (16) @(negedge clk);
        rst_b = 1'b1;
        t_hold;
        t_cal;
        t_init;
        t_map;
        t_ecc;
        wrap_up;
    end
endmodule  // ddrbu_ctrl_tb
`default_nettype wire
